// [hdl/tas_pkg.sv]
// Constants and carrier types for the T1/E1 alarm status and mask block
package tas_pkg;
	// Register offsets on the parallel port
	localparam logic [7:0] ADDR_IDENT = 8'h0f;
	localparam logic [7:0] ADDR_LINE_STAT = 8'h18;
	localparam logic [7:0] ADDR_LINE_MASK = 8'h19;
	localparam logic [7:0] ADDR_LINK_STAT = 8'h1a;
	localparam logic [7:0] ADDR_LINK_MASK = 8'h1b;
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h70;

	// Field positions in common_control_one
	localparam int unsigned CTRL_LOSS_FN_BIT = 0;
	localparam int unsigned CTRL_CRC_RECALC_BIT = 6;
	localparam int unsigned CTRL_MCLK_SRC_BIT = 7;

	// Field positions in line_alarm_status
	localparam int unsigned STAT_SYNC_LOSS_BIT = 0;
	localparam int unsigned STAT_SYNC_CLR_BIT = 4;

	// Reset values
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Consecutive zeros that declare carrier loss
	localparam logic [11:0] CL_ZEROS_E1 = 12'h0ff;
	localparam logic [11:0] CL_ZEROS_E1_EXT = 12'h800;
	localparam logic [11:0] CL_ZEROS_T1 = 12'h0c0;

	// Channel time (8 line bits) as a least time, rounded up to cycles
	localparam int unsigned CLK_PERIOD_PS = 8000;
	localparam int unsigned CHAN_E1_PS = 3906250;
	localparam int unsigned CHAN_T1_PS = 5181347;
	localparam logic [9:0] CHAN_E1_CYC =
		10'((CHAN_E1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [9:0] CHAN_T1_CYC =
		10'((CHAN_T1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// Conditions reported by the line-side detectors
	typedef struct packed {
		logic sync_loss;
		logic all_ones;
		logic yellow;
		logic remote;
		logic dma;
		logic v5;
		logic loop_up;
		logic loop_down;
		logic spare;
	} tas_cond_s;

	// One parallel-port access
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} tas_bus_s;
endpackage : tas_pkg

// [hdl/tas_alarm_irq.sv]
// Alarm status latching, interrupt masking and common control bits
// What this block does
// - CRC recalc bit 0 selects normal CRC-4, 1 selects intermediate recalculation.
// - Master clock source bit picks dedicated pin at 0, system clock at 1.
// - Identification register is read-only; low nibble is die revision.
// - Upper identification nibble returns a fixed device identity code.
// - Sync loss bit is set while receiver is unsynchronized.
// - Carrier loss after 255/2048 zeros in E1, 192 in T1.
// - Unframed all-ones bit is set while that pattern arrives.
// - Yellow alarm bit set while yellow received, T1 mode only.
// - Sync loss clear event sets on gaining sync, held until read.
// - Carrier, all-ones, yellow clear events set when the condition ends.
// - First mask enables status interrupts; conditions fire on rising edge.
// - Remote alarm bit in E1 mode, interrupting on both edges.
// - Distant multiframe alarm bit in E1 mode, also under CCS.
// - V5.2 link bit in E1 mode when link identification seen.
// - Receive clock loss after one channel time without transition.
// - Transmit clock loss after one channel time; may drive loss output.
// - Loop-up, loop-down, spare code bits in T1 while code received.
// - Second mask bits enable both-edge interrupts; zero masks them.
// - Loss output function picks sync loss at 0, transmit clock loss at 1.
// - Loop code mask bits also enable both-edge interrupts.
`timescale 1ns/1ps
module tas_alarm_irq
	import tas_pkg::*;
#(
	parameter logic [3:0] DIE_REVISION = 4'h1, // Arbitrary value
	parameter logic [3:0] DEVICE_IDENTITY = 4'h5 // Arbitrary value
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Parallel register port
	input wire tas_bus_s host_bus,
	output logic [7:0] host_rdata,
	output logic irq_n,
	// Line-side detectors and pins
	input wire tas_cond_s det_cond,
	input wire logic e1_mode,
	input wire logic carrier_ext_threshold,
	input wire logic rx_bit_strobe,
	input wire logic receive_positive_input,
	input wire logic receive_negative_input,
	input wire logic receive_clock_input,
	input wire logic transmit_clock_pin,
	// Control outputs
	output logic crc_recalc_select,
	output logic master_clock_source_select,
	output logic loss_output
);
	logic [7:0] ctrl_reg;
	logic [7:0] line_mask_reg;
	logic [7:0] link_mask_reg;
	logic [15:0] stat_reg;
	logic [15:0] pend_reg;
	logic [15:0] cond_reg;
	logic [11:0] zero_cnt_reg;
	logic [1:0] clk_smp_reg;
	logic [9:0] idle_cnt_reg [2];
	logic [7:0] rdata_reg;
	logic irq_n_reg;
	logic crc_reg;
	logic mclk_reg;
	logic loss_reg;

	// Address decode
	wire logic sel_ident = host_bus.addr == ADDR_IDENT;
	wire logic sel_lstat = host_bus.addr == ADDR_LINE_STAT;
	wire logic sel_lmask = host_bus.addr == ADDR_LINE_MASK;
	wire logic sel_kstat = host_bus.addr == ADDR_LINK_STAT;
	wire logic sel_kmask = host_bus.addr == ADDR_LINK_MASK;
	wire logic sel_ctrl = host_bus.addr == ADDR_CTRL_ONE;
	wire logic wr_lmask = host_bus.wr && sel_lmask;
	wire logic wr_kmask = host_bus.wr && sel_kmask;
	wire logic wr_ctrl = host_bus.wr && sel_ctrl;
	wire logic rd_lstat = host_bus.rd && sel_lstat;
	wire logic rd_kstat = host_bus.rd && sel_kstat;
	wire logic [15:0] rd_clr = {{8{rd_kstat}}, {8{rd_lstat}}};

	// Carrier loss: consecutive zeros on both rails, saturating
	wire logic rx_zero = !receive_positive_input && !receive_negative_input;
	wire logic [11:0] cl_limit = !e1_mode ? CL_ZEROS_T1 :
		(carrier_ext_threshold ? CL_ZEROS_E1_EXT : CL_ZEROS_E1);
	wire logic carrier_loss = zero_cnt_reg >= cl_limit;
	wire logic [11:0] zero_cnt_next = !rx_bit_strobe ? zero_cnt_reg :
		(!rx_zero ? 12'h000 :
		(carrier_loss ? zero_cnt_reg : zero_cnt_reg + 12'h001));

	// Clock watchdogs, index 0 receive clock, 1 transmit clock
	wire logic [1:0] clk_pin = {transmit_clock_pin, receive_clock_input};
	wire logic [9:0] chan_cyc = e1_mode ? CHAN_E1_CYC : CHAN_T1_CYC;
	logic [1:0] clk_lost;
	logic [9:0] idle_cnt_next [2];
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_clk_watch
			assign clk_lost[c] = idle_cnt_reg[c] >= chan_cyc;
			assign idle_cnt_next[c] = (clk_pin[c] != clk_smp_reg[c]) ?
				10'h000 : (clk_lost[c] ? idle_cnt_reg[c] :
				idle_cnt_reg[c] + 10'h001);
		end
	endgenerate

	// Live conditions; yellow, E1 alarm and T1 code bits gated by line mode
	wire logic [7:0] line_cond = {4'h0,
		det_cond.yellow && !e1_mode,
		det_cond.all_ones,
		carrier_loss,
		det_cond.sync_loss};
	wire logic [7:0] link_cond = {
		det_cond.spare && !e1_mode,
		det_cond.loop_down && !e1_mode,
		det_cond.loop_up && !e1_mode,
		clk_lost[1],
		clk_lost[0],
		det_cond.v5 && e1_mode,
		det_cond.dma && e1_mode,
		det_cond.remote && e1_mode};
	wire logic [15:0] cond_now = {link_cond, line_cond};
	wire logic [15:0] rise = cond_now & ~cond_reg;
	wire logic [15:0] fall = ~cond_now & cond_reg;

	// Condition bits latch the level, clear events latch the fall
	wire logic [15:0] stat_set = {link_cond,
		fall[3:0],
		line_cond[3:0]};
	// Line conditions interrupt on rise only, link bits on both edges
	wire logic [15:0] irq_evt = {rise[15:8] | fall[15:8],
		fall[3:0], rise[3:0]};
	wire logic [15:0] mask_all = {link_mask_reg, line_mask_reg};

	// Status bits: set wins over clear-on-read
	logic [15:0] stat_next;
	logic [15:0] pend_next;
	genvar b;
	generate
		for (b = 0; b < 16; b++) begin : g_stat
			assign stat_next[b] = stat_set[b] ||
				(stat_reg[b] && !rd_clr[b]);
			assign pend_next[b] = irq_evt[b] ||
				(pend_reg[b] && !rd_clr[b]);
		end
	endgenerate

	wire logic irq_next = |(pend_reg & mask_all);

	// Read mux; unmapped addresses read as zero
	wire logic [7:0] rd_mux =
		sel_ident ? {DEVICE_IDENTITY, DIE_REVISION} :
		sel_lstat ? stat_reg[7:0] :
		sel_lmask ? line_mask_reg :
		sel_kstat ? stat_reg[15:8] :
		sel_kmask ? link_mask_reg :
		sel_ctrl ? ctrl_reg : 8'h00;
	wire logic [7:0] rdata_next = host_bus.rd ? rd_mux : rdata_reg;

	wire logic [7:0] ctrl_next = wr_ctrl ? host_bus.wdata : ctrl_reg;
	wire logic [7:0] lmask_next = wr_lmask ? host_bus.wdata : line_mask_reg;
	wire logic [7:0] kmask_next = wr_kmask ? host_bus.wdata : link_mask_reg;
	wire logic loss_next = ctrl_reg[CTRL_LOSS_FN_BIT] ?
		clk_lost[1] : line_cond[STAT_SYNC_LOSS_BIT];

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RESET;
			line_mask_reg <= MASK_RESET;
			link_mask_reg <= MASK_RESET;
			stat_reg <= {STAT_RESET, STAT_RESET};
			pend_reg <= 16'h0000;
			cond_reg <= 16'h0000;
		end else begin
			ctrl_reg <= ctrl_next;
			line_mask_reg <= lmask_next;
			link_mask_reg <= kmask_next;
			stat_reg <= stat_next;
			pend_reg <= pend_next;
			cond_reg <= cond_now;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			zero_cnt_reg <= 12'h000;
			clk_smp_reg <= 2'h0;
			idle_cnt_reg[0] <= 10'h000;
			idle_cnt_reg[1] <= 10'h000;
		end else begin
			zero_cnt_reg <= zero_cnt_next;
			clk_smp_reg <= clk_pin;
			idle_cnt_reg[0] <= idle_cnt_next[0];
			idle_cnt_reg[1] <= idle_cnt_next[1];
		end
	end

	// Outputs straight from flops
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
			irq_n_reg <= 1'b1;
			crc_reg <= 1'b0;
			mclk_reg <= 1'b0;
			loss_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			irq_n_reg <= !irq_next;
			crc_reg <= ctrl_reg[CTRL_CRC_RECALC_BIT];
			mclk_reg <= ctrl_reg[CTRL_MCLK_SRC_BIT];
			loss_reg <= loss_next;
		end
	end

	assign host_rdata = rdata_reg;
	assign irq_n = irq_n_reg;
	assign crc_recalc_select = crc_reg;
	assign master_clock_source_select = mclk_reg;
	assign loss_output = loss_reg;

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_crc_select_follows:
	assert property (wr_ctrl |-> ##2
		crc_recalc_select == $past(host_bus.wdata[CTRL_CRC_RECALC_BIT], 2))
	else $error("crc recalc select does not follow control write");

	a_mclk_select_follows:
	assert property (wr_ctrl |-> ##2 master_clock_source_select ==
		$past(host_bus.wdata[CTRL_MCLK_SRC_BIT], 2))
	else $error("clock source select does not follow control write");

	a_ident_read_value:
	assert property (host_bus.rd && sel_ident |=>
		host_rdata == {DEVICE_IDENTITY, DIE_REVISION})
	else $error("identification read returned wrong value");

	a_sync_loss_level:
	assert property (det_cond.sync_loss |=> stat_reg[STAT_SYNC_LOSS_BIT])
	else $error("sync loss status not set while unsynchronized");

	a_carrier_t1_limit:
	assert property (!e1_mode && zero_cnt_reg == CL_ZEROS_T1 - 12'h001 &&
		rx_bit_strobe && rx_zero |=> carrier_loss)
	else $error("carrier loss not declared at T1 zero count");

	a_yellow_t1_only:
	assert property (e1_mode && !$past(stat_reg[3]) && !stat_reg[3]
		|=> !(stat_reg[3] && $past(e1_mode)))
	else $error("yellow alarm set in E1 mode");

	a_sync_clear_event:
	assert property ($fell(cond_reg[0]) |-> stat_reg[STAT_SYNC_CLR_BIT])
	else $error("sync loss clear event missed");

	a_event_held_till_read:
	assert property (stat_reg[STAT_SYNC_CLR_BIT] && !rd_lstat
		|=> stat_reg[STAT_SYNC_CLR_BIT])
	else $error("clear event dropped before read");

	a_link_both_edges:
	assert property ($fell(cond_reg[13]) && link_mask_reg[5] |=> !irq_n)
	else $error("loop-up falling edge raised no interrupt");

	a_line_rise_only:
	assert property (pend_reg == 16'h0000 && fall[0] && !(|rise) &&
		!(|fall[15:1]) && mask_all == 16'h0001 && !wr_lmask
		|=> ##1 irq_n)
	else $error("sync loss fall interrupted despite rise-only mode");

	a_irq_tracks_pend:
	assert property (|(pend_reg & mask_all) |=> !irq_n)
	else $error("interrupt not asserted for pending enabled event");

	a_loss_output_mux:
	assert property (ctrl_reg[CTRL_LOSS_FN_BIT] && $stable(clk_lost[1])
		|=> loss_output == $past(clk_lost[1]))
	else $error("loss output does not show transmit clock loss");

	a_ones_level:
	assert property (det_cond.all_ones |=> stat_reg[2])
	else $error("all-ones status not set while pattern arrives");

	a_carrier_clear_event:
	assert property ($fell(cond_reg[1]) |-> stat_reg[5])
	else $error("carrier loss clear event missed");

	a_ones_clear_event:
	assert property ($fell(cond_reg[2]) |-> stat_reg[6])
	else $error("all-ones clear event missed");

	a_yellow_clear_event:
	assert property ($fell(cond_reg[3]) |-> stat_reg[7])
	else $error("yellow alarm clear event missed");

	a_remote_level:
	assert property (det_cond.remote && e1_mode |=> stat_reg[8])
	else $error("remote alarm status not set in E1 mode");

	a_remote_both_edges:
	assert property ($fell(cond_reg[8]) && link_mask_reg[0] |=> !irq_n)
	else $error("remote alarm falling edge raised no interrupt");

	a_dma_level:
	assert property (det_cond.dma && e1_mode |=> stat_reg[9])
	else $error("distant multiframe alarm status not set");

	a_v5_level:
	assert property (det_cond.v5 && e1_mode |=> stat_reg[10])
	else $error("link identification status not set");

	a_e1_bits_gated:
	assert property (!e1_mode |=> cond_reg[10:8] == 3'h0)
	else $error("E1-only condition reported in T1 mode");

	a_loop_level:
	assert property (det_cond.loop_up && !e1_mode |=> stat_reg[13])
	else $error("loop-up code status not set in T1 mode");

	a_loops_t1_only:
	assert property (e1_mode |=> cond_reg[15:13] == 3'h0)
	else $error("loop code condition reported in E1 mode");

	a_rx_clock_loss:
	assert property (clk_lost[0] |=> stat_reg[11])
	else $error("receive clock loss not reported");

	a_tx_clock_loss:
	assert property (clk_lost[1] |=> stat_reg[12])
	else $error("transmit clock loss not reported");

	a_masked_no_irq:
	assert property ((pend_reg & mask_all) == 16'h0000 |=> irq_n)
	else $error("interrupt asserted with nothing enabled pending");

	a_reset_values:
	assert property ($rose(rst_n) |-> stat_reg == 16'h0000 &&
		pend_reg == 16'h0000 && mask_all == 16'h0000 && irq_n)
	else $error("status or mask not cleared by reset");

	a_carrier_e1_limit:
	assert property (e1_mode && !carrier_ext_threshold &&
		zero_cnt_reg == CL_ZEROS_E1 |-> carrier_loss)
	else $error("carrier loss not declared at E1 zero count");

	a_carrier_ext_limit:
	assert property (e1_mode && carrier_ext_threshold &&
		zero_cnt_reg == CL_ZEROS_E1 |-> !carrier_loss)
	else $error("carrier loss declared early with extended threshold");

	a_zero_count_resets:
	assert property (rx_bit_strobe && !rx_zero |=> zero_cnt_reg == 12'h000)
	else $error("zero count not restarted by a received one");

	c_carrier_loss: cover property ($rose(carrier_loss));
	c_irq_raised: cover property ($fell(irq_n));
	c_transmit_clock_pin_lost: cover property ($rose(clk_lost[1]));
	c_read_clears: cover property (rd_lstat && stat_reg[4] ##1 !stat_reg[4]);
endmodule : tas_alarm_irq

// [verif/tas_host_model.sv]
// Host processor model that reaches the registers over the parallel port
`timescale 1ns/1ps
module tas_host_model
	import tas_pkg::*;
(
	// Clock
	clk_sys,
	// Register port
	host_bus,
	host_rdata
);
	input wire logic clk_sys;
	output tas_bus_s host_bus;
	input wire logic [7:0] host_rdata;
	initial host_bus = '{8'hff, 1'b0, 1'b0, 8'hff};
	// Address and data are scrambled when idle so nothing leans on them
	task automatic access(input logic [7:0] a, input logic w,
		input logic [7:0] d_w);
		@(posedge clk_sys);
		host_bus <= '{a, w, !w, d_w};
		@(posedge clk_sys);
		host_bus <= '{~a, 1'b0, 1'b0, ~d_w};
	endtask : access
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		access(a, 1'b1, d);
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		access(a, 1'b0, 8'h00);
		@(posedge clk_sys);
		#1 d = host_rdata;
	endtask : reg_read
endmodule : tas_host_model

// [verif/tas_alarm_irq_test.sv]
// Self-checking bench for the alarm status and interrupt mask block
`timescale 1ns/1ps
module tas_alarm_irq_test import tas_pkg::*;;
	localparam logic [3:0] ID_DEV = 4'h5; // Arbitrary value
	localparam logic [3:0] ID_REV = 4'h1; // Arbitrary value
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	tas_bus_s host_bus;
	logic [7:0] host_rdata;
	logic [7:0] rd;
	logic irq_n, crc, mclk, loss_output;
	tas_cond_s det_cond = '0;
	logic e1_mode = 1'b0;
	logic ext_thr = 1'b0;
	logic strobe = 1'b0;
	logic rpos = 1'b0;
	logic rneg = 1'b0;
	logic clk_run = 1'b1;
	logic rxclk = 1'b0;
	logic txclk = 1'b0;
	int n_errors = 0;
	int check_count = 0;
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		rxclk <= clk_run ? ~rxclk : rxclk;
		txclk <= clk_run ? ~txclk : txclk;
	end
	tas_alarm_irq #(.DIE_REVISION(ID_REV), .DEVICE_IDENTITY(ID_DEV)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .host_bus(host_bus),
		.host_rdata(host_rdata), .irq_n(irq_n), .det_cond(det_cond),
		.e1_mode(e1_mode), .carrier_ext_threshold(ext_thr),
		.rx_bit_strobe(strobe), .receive_positive_input(rpos),
		.receive_negative_input(rneg), .receive_clock_input(rxclk),
		.transmit_clock_pin(txclk), .crc_recalc_select(crc),
		.master_clock_source_select(mclk), .loss_output(loss_output));
	tas_host_model host (.clk_sys(clk_sys), .host_bus(host_bus),
		.host_rdata(host_rdata));
	task automatic check(input string w, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask : check
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wt
	task automatic rc(input string w, input logic [7:0] a, m, e);
		host.reg_read(a, rd);
		check(w, e, rd & m);
	endtask : rc
	task automatic irq(input string w, input logic e);
		wt(3);
		check(w, {7'h0, e}, {7'h0, irq_n});
	endtask : irq
	// Bit order, msb first: sync, ones, yellow, remote, dma, v5, up, down, spare
	task automatic setc(input logic [8:0] c);
		@(posedge clk_sys);
		det_cond <= tas_cond_s'(c);
	endtask : setc
	task automatic flush;
		wt(3);
		repeat (2) begin
			host.reg_read(ADDR_LINE_STAT, rd);
			host.reg_read(ADDR_LINK_STAT, rd);
		end
	endtask : flush
	task automatic bits(input int n, input logic [1:0] r);
		repeat (n) begin
			@(posedge clk_sys);
			strobe <= 1'b1;
			{rpos, rneg} <= r;
			@(posedge clk_sys);
			strobe <= 1'b0;
		end
	endtask : bits
	task automatic t_reset;
		rc("ident", ADDR_IDENT, 8'hff, {ID_DEV, ID_REV});
		host.reg_write(ADDR_IDENT, 8'h00);
		rc("ident_ro", ADDR_IDENT, 8'hff, {ID_DEV, ID_REV});
		rc("line_st", ADDR_LINE_STAT, 8'hff, 8'h00);
		rc("line_mk", ADDR_LINE_MASK, 8'hff, 8'h00);
		rc("link_st", ADDR_LINK_STAT, 8'hff, 8'h00);
		rc("link_mk", ADDR_LINK_MASK, 8'hff, 8'h00);
		rc("unmapped", 8'h3c, 8'hff, 8'h00);
		irq("irq_rst", 1'b1);
	endtask : t_reset
	task automatic t_ctrl;
		host.reg_write(ADDR_CTRL_ONE, 8'h40);
		wt(2);
		check("crc_mclk", 8'h02, {6'h0, crc, mclk});
		host.reg_write(ADDR_CTRL_ONE, 8'h80);
		wt(2);
		check("crc_mclk0", 8'h01, {6'h0, crc, mclk});
	endtask : t_ctrl
	task automatic t_sync;
		host.reg_write(ADDR_LINE_MASK, 8'h11);
		setc(9'h100);
		irq("sync_irq", 1'b0);
		check("loss_sync", 8'h01, {7'h0, loss_output});
		rc("sync", ADDR_LINE_STAT, 8'h01, 8'h01);
		irq("edge_only", 1'b1);
		setc(9'h000);
		irq("clr_ev_irq", 1'b0);
		rc("sync_clr", ADDR_LINE_STAT, 8'h10, 8'h10);
		rc("sync_clr_rd", ADDR_LINE_STAT, 8'h10, 8'h00);
		irq("irq_idle", 1'b1);
		host.reg_write(ADDR_LINE_MASK, 8'h01);
		setc(9'h100);
		irq("rise_irq", 1'b0);
		rc("rise_rd", ADDR_LINE_STAT, 8'h11, 8'h01);
		setc(9'h000);
		irq("no_fall_irq", 1'b1);
		rc("fall_ev", ADDR_LINE_STAT, 8'h10, 8'h10);
		host.reg_write(ADDR_LINE_MASK, 8'h00);
		setc(9'h080);
		irq("masked", 1'b1);
		rc("all_ones", ADDR_LINE_STAT, 8'h04, 8'h04);
		setc(9'h000);
		irq("masked_clr", 1'b1);
		rc("ones_clr", ADDR_LINE_STAT, 8'h40, 8'h40);
	endtask : t_sync
	task automatic t_link;
		@(posedge clk_sys);
		e1_mode <= 1'b1;
		host.reg_write(ADDR_LINK_MASK, 8'h01);
		setc(9'h020);
		irq("rra_rise", 1'b0);
		rc("remote", ADDR_LINK_STAT, 8'h01, 8'h01);
		irq("rra_rd", 1'b1);
		setc(9'h000);
		irq("rra_fall", 1'b0);
		host.reg_read(ADDR_LINK_STAT, rd);
		irq("rra_rd2", 1'b1);
		setc(9'h018);
		irq("link_mask", 1'b1);
		rc("dma_v5", ADDR_LINK_STAT, 8'h06, 8'h06);
		setc(9'h047);
		flush();
		rc("yel_e1", ADDR_LINE_STAT, 8'h08, 8'h00);
		rc("loop_e1", ADDR_LINK_STAT, 8'he0, 8'h00);
		@(posedge clk_sys);
		e1_mode <= 1'b0;
		host.reg_write(ADDR_LINK_MASK, 8'he0);
		irq("loop_irq", 1'b0);
		rc("yel_t1", ADDR_LINE_STAT, 8'h08, 8'h08);
		rc("loop_t1", ADDR_LINK_STAT, 8'he0, 8'he0);
		setc(9'h038);
		irq("loop_fall", 1'b0);
		rc("e1_in_t1", ADDR_LINK_STAT, 8'h07, 8'h00);
		rc("yel_clr", ADDR_LINE_STAT, 8'h80, 8'h80);
		setc(9'h000);
		host.reg_write(ADDR_LINK_MASK, 8'h00);
		flush();
	endtask : t_link
	task automatic t_carrier(input int n, input logic e, x);
		@(posedge clk_sys);
		e1_mode <= e;
		ext_thr <= x;
		bits(1, 2'b01);
		flush();
		bits(n - 1, 2'b00);
		wt(3);
		rc("cl_short", ADDR_LINE_STAT, 8'h02, 8'h00);
		bits(1, 2'b00);
		wt(3);
		rc("cl_set", ADDR_LINE_STAT, 8'h02, 8'h02);
		bits(1, 2'b10);
		wt(3);
		rc("cl_clr", ADDR_LINE_STAT, 8'h20, 8'h20);
	endtask : t_carrier
	task automatic t_clk;
		host.reg_write(ADDR_CTRL_ONE, 8'h01);
		@(posedge clk_sys);
		e1_mode <= 1'b0;
		clk_run <= 1'b0;
		wt(600);
		rc("clk_early", ADDR_LINK_STAT, 8'h18, 8'h00);
		wt(100);
		rc("clk_lost", ADDR_LINK_STAT, 8'h18, 8'h18);
		check("loss_tx", 8'h01, {7'h0, loss_output});
		@(posedge clk_sys);
		clk_run <= 1'b1;
		wt(5);
		check("loss_back", 8'h00, {7'h0, loss_output});
	endtask : t_clk
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_ctrl();
		t_sync();
		t_link();
		t_carrier(192, 1'b0, 1'b0);
		t_carrier(255, 1'b1, 1'b0);
		t_carrier(2048, 1'b1, 1'b1);
		t_clk();
		print_verdict();
	end
endmodule : tas_alarm_irq_test
